// >>> cbd_branch.sv
/*
 * Conditional relative branch decoder and executor. Holds the program
 * counter, steps it by one instruction word per cycle and rewrites it for
 * taken branches of the three not-flag kinds.
 * Assumes: instr_word is valid from Q1 of each instruction cycle, flags are
 * stable during Q1..Q3, and fetch honours fetch_hold (the dead cycle).
 */
// Summary of operation
// - word with upper byte e7 branches when negative flag is clear.
// - word with upper byte e5 branches when overflow flag is clear.
// - word with upper byte e1 branches when zero flag is clear.
// - target is instruction address plus two plus twice the offset.
// - offset byte is signed, doubled and sign-extended before addition.
// - taken branch uses two cycles; second cycle does nothing.
`timescale 1ns/1ps
`include "cbd_map.svh"

module cbd_branch
    import cbd_pkg::*;
#(
    parameter int PC_W = 21
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // fetch side
    input  wire logic [15:0]      instr_word,
    input  wire logic             instr_valid,
    input  wire cbd_flags_s       flags,
    // program counter side
    output logic      [PC_W-1:0]  pc,
    output logic                  pc_write,
    output logic                  fetch_hold,
    output logic      [1:0]       q_phase,
    output logic                  branch_taken,
    output logic                  is_branch
);

    cbd_state_s s_q;
    cbd_state_s s_d;
    cbd_op_e    op;
    logic       cond_ok;
    logic [20:0] ofs2;

    always_comb begin
        op = CBD_OP_NONE;
        if (instr_valid) begin
            unique case (instr_word[`CBD_OPC_HI:`CBD_OPC_LO])
                `CBD_OP_NOT_NEG:  op = CBD_OP_NOT_NEG;
                `CBD_OP_NOT_OVF:  op = CBD_OP_NOT_OVF;
                `CBD_OP_NOT_ZERO: op = CBD_OP_NOT_ZERO;
                default:          op = CBD_OP_NONE;
            endcase
        end
    end

    always_comb begin
        unique case (op)
            CBD_OP_NOT_NEG:  cond_ok = !flags.negative;
            CBD_OP_NOT_OVF:  cond_ok = !flags.overflow;
            CBD_OP_NOT_ZERO: cond_ok = !flags.zero;
            CBD_OP_NONE:     cond_ok = 1'b0;
        endcase
    end

    assign ofs2 = {{`CBD_OFS_EXT{instr_word[`CBD_OFS_HI]}}, instr_word[`CBD_OFS_HI:`CBD_OFS_LO], 1'b0};

    always_comb begin
        s_d = s_q;
        s_d.pc_we = 1'b0;
        s_d.phase = s_q.phase + 2'h1;
        unique case (s_q.state)
            CBD_ST_EXEC: begin
                unique case (s_q.phase)
                    `CBD_Q1: begin
                        s_d.busy  = (op != CBD_OP_NONE);
                        s_d.base  = s_q.pc;
                        s_d.taken = 1'b0;
                    end
                    `CBD_Q2: begin
                        s_d.target = s_q.base + `CBD_PC_STEP + ofs2;
                    end
                    `CBD_Q3: begin
                        s_d.taken = cond_ok;
                        s_d.stall = cond_ok;
                    end
                    `CBD_Q4: begin
                        s_d.busy = 1'b0;
                        if (s_q.taken) begin
                            // write pc, then one dead cycle
                            s_d.pc    = s_q.target;
                            s_d.pc_we = 1'b1;
                            s_d.state = CBD_ST_IDLE;
                        end else begin
                            // untaken: plain step, no write of target
                            s_d.pc = s_q.pc + `CBD_PC_STEP;
                        end
                    end
                endcase
            end
            CBD_ST_IDLE: begin
                if (s_q.phase == `CBD_Q4) begin
                    s_d.state = CBD_ST_EXEC;
                    s_d.stall = 1'b0;
                    s_d.taken = 1'b0;
                end
            end
            default: s_d.state = CBD_ST_EXEC;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{state: CBD_ST_EXEC, phase: `CBD_Q1, pc: `CBD_PC_RST, base: `CBD_PC_RST,
                     target: `CBD_PC_RST, taken: 1'b0, pc_we: 1'b0, stall: 1'b0, busy: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pc           = s_q.pc[PC_W-1:0];
    assign pc_write     = s_q.pc_we;
    assign fetch_hold   = s_q.stall;
    assign q_phase      = s_q.phase;
    assign branch_taken = s_q.taken;
    assign is_branch    = s_q.busy;

    AST_TARGET: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q4 && s_q.taken)
        |=> (s_q.pc == $past(s_q.base) + `CBD_PC_STEP + $past(s_q.target - s_q.base - `CBD_PC_STEP)))
        else $error("branch target not loaded");

    // dead cycle after a taken branch holds fetch for all four phases
    AST_DEAD_CYCLE: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(s_q.state == CBD_ST_IDLE) |-> (s_q.state == CBD_ST_IDLE && fetch_hold)[*4] ##1 !fetch_hold)
        else $error("dead cycle length wrong");

    // untaken steps pc by one word
    AST_UNTAKEN: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q4 && !s_q.taken)
        |=> (s_q.pc == $past(s_q.pc) + `CBD_PC_STEP && !pc_write))
        else $error("untaken branch disturbed pc");

    AST_NOT_NEG: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q3 && op == CBD_OP_NOT_NEG)
        |=> (s_q.taken == !$past(flags.negative)))
        else $error("negative test wrong");

    AST_NOT_OVF: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q3 && op == CBD_OP_NOT_OVF)
        |=> (s_q.taken == !$past(flags.overflow)))
        else $error("overflow test wrong");

    AST_NOT_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q3 && op == CBD_OP_NOT_ZERO)
        |=> (s_q.taken == !$past(flags.zero)))
        else $error("zero test wrong");

    AST_SIGN: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q2)
        |=> (s_q.target - s_q.base - `CBD_PC_STEP
             == {{`CBD_OFS_EXT{$past(instr_word[`CBD_OFS_HI])}},
                 $past(instr_word[`CBD_OFS_HI:`CBD_OFS_LO]), 1'b0}))
        else $error("offset not sign extended");

    // pc write only in phase one of the dead cycle
    AST_WRITE_PHASE: assert property (@(posedge core_clk) disable iff (!arst_n)
        pc_write |-> (s_q.phase == `CBD_Q1 && s_q.state == CBD_ST_IDLE && fetch_hold))
        else $error("pc write out of phase");

    AST_PHASE_STEP: assert property (@(posedge core_clk) disable iff (!arst_n)
        1'b1
        |=> (q_phase == $past(q_phase) + 2'h1))
        else $error("phase did not advance");

    AST_BUSY_SPAN: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q1 && op != CBD_OP_NONE)
        |=> is_branch[*3] ##1 !is_branch)
        else $error("branch marker span wrong");

    AST_NONE_UNTAKEN: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q3 && op == CBD_OP_NONE)
        |=> !branch_taken)
        else $error("non-branch word taken");

    AST_HOLD_START: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q3 && cond_ok)
        |=> (fetch_hold && branch_taken && q_phase == `CBD_Q4))
        else $error("hold not raised for taken branch");

    AST_NO_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_EXEC && s_q.phase == `CBD_Q3 && !cond_ok)
        |=> (!fetch_hold && !branch_taken))
        else $error("hold raised without branch");

    AST_DEAD_PC: assert property (@(posedge core_clk) disable iff (!arst_n)
        (s_q.state == CBD_ST_IDLE)
        |=> $stable(pc))
        else $error("pc moved in dead cycle");

    AST_ONE_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
        pc_write
        |=> !pc_write)
        else $error("pc write longer than one clock");

    AST_RESUME: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(fetch_hold)
        |-> (s_q.state == CBD_ST_EXEC && q_phase == `CBD_Q1 && !branch_taken))
        else $error("fetch resumed out of phase");

endmodule

// >>> cbd_fetch_model.sv
/*
 * Fetch-side partner model: presents the instruction word and status flags.
 * Assumes the bench loads word, valid and flags at rising edges.
 */
`timescale 1ns/1ps
module cbd_fetch_model
    import cbd_pkg::*;
(
    // from bench
    input  wire logic [15:0] bench_word,
    input  wire logic        bench_valid,
    input  wire cbd_flags_s  bench_flags,
    // decoder side
    input  wire logic        fetch_hold,
    output logic      [15:0] instr_word,
    output logic             instr_valid,
    output cbd_flags_s       flags
);
    // word shown inverted while fetch_hold is high, so the held word is not shown as is
    assign instr_word  = fetch_hold ? ~bench_word : bench_word;
    assign instr_valid = bench_valid;
    assign flags       = bench_flags;
endmodule

// >>> cbd_map.svh
/*
 * Constants for the conditional relative branch decoder: opcode bytes,
 * field positions, phase codes and reset values.
 * Assumes inclusion by bare name from the decoder module.
 */
`ifndef CBD_MAP_SVH
`define CBD_MAP_SVH

`define CBD_OP_NOT_NEG      8'he7
`define CBD_OP_NOT_OVF      8'he5
`define CBD_OP_NOT_ZERO     8'he1
`define CBD_OPC_HI          15
`define CBD_OPC_LO          8
`define CBD_OFS_HI          7
`define CBD_OFS_LO          0
`define CBD_OFS_EXT         12
`define CBD_PC_STEP         21'h000002
`define CBD_PC_RST          21'h000000
`define CBD_Q1              2'h0
`define CBD_Q2              2'h1
`define CBD_Q3              2'h2
`define CBD_Q4              2'h3

`endif

// >>> cbd_pkg.sv
/*
 * Types for the conditional relative branch decoder.
 * Assumes cbd_map.svh is on the include path.
 */
package cbd_pkg;
    typedef enum logic [1:0] {
        CBD_ST_EXEC = 2'b00,
        CBD_ST_IDLE = 2'b01
    } cbd_state_e;

    typedef enum logic [1:0] {
        CBD_OP_NONE     = 2'b00,
        CBD_OP_NOT_NEG  = 2'b01,
        CBD_OP_NOT_OVF  = 2'b10,
        CBD_OP_NOT_ZERO = 2'b11
    } cbd_op_e;

    typedef struct packed {
        logic negative;
        logic overflow;
        logic zero;
    } cbd_flags_s;

    typedef struct packed {
        cbd_state_e  state;
        logic [1:0]  phase;
        logic [20:0] pc;
        logic [20:0] base;
        logic [20:0] target;
        logic        taken;
        logic        pc_we;
        logic        stall;
        logic        busy;
    } cbd_state_s;
endpackage

// >>> tb.sv
/*
 * Self-checking bench for cbd_branch: branch words through the fetch model.
 * Assumes cbd_pkg is compiled first.
 */
`timescale 1ns/1ps
module tb;
    import cbd_pkg::*;
    logic        core_clk;
    logic        arst_n;
    logic        valid_in;
    logic        instr_valid;
    logic [15:0] word_in;
    logic [15:0] instr_word;
    cbd_flags_s  flags_in;
    cbd_flags_s  flags;
    logic [20:0] pc;
    logic [20:0] exp_pc;
    logic        pc_write;
    logic        fetch_hold;
    logic        branch_taken;
    logic        is_branch;
    logic [1:0]  q_phase;
    int          fail_count = 0;
    int          checked = 0;
    int          cyc = 0;

    cbd_fetch_model cbd_fetch_model_i (.bench_word(word_in), .bench_valid(valid_in), .bench_flags(flags_in),
        .fetch_hold(fetch_hold), .instr_word(instr_word), .instr_valid(instr_valid), .flags(flags));
    cbd_branch cbd_branch_i (.core_clk(core_clk), .arst_n(arst_n), .instr_word(instr_word),
        .instr_valid(instr_valid), .flags(flags), .pc(pc), .pc_write(pc_write), .fetch_hold(fetch_hold),
        .q_phase(q_phase), .branch_taken(branch_taken), .is_branch(is_branch));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task final_report;
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask

    // one instruction from the fourth phase of a free cycle on
    task automatic br(input logic [7:0] op, input logic [7:0] ofs, input logic [2:0] f,
                      input logic v, input logic tk, input logic isb);
        @(negedge core_clk);
        while (!(q_phase === 2'h3 && fetch_hold === 1'b0)) @(negedge core_clk);
        @(posedge core_clk);
        word_in  <= {op, ofs};
        valid_in <= v;
        flags_in <= cbd_flags_s'(f);
        @(negedge core_clk);
        exp_pc = pc + 21'h000002 + (tk ? {{12{ofs[7]}}, ofs, 1'b0} : 21'h000000);
        repeat (3) @(negedge core_clk);
        chk(branch_taken === tk && is_branch === isb, "taken or decode flag wrong");
        chk(fetch_hold === tk, "hold wrong in fourth phase");
        // retire the word at Q4 so the next Q1 fetches a plain valid word
        @(posedge core_clk);
        word_in  <= 16'h0000;
        valid_in <= 1'b1;
        @(negedge core_clk);
        chk(pc === exp_pc, "pc wrong after branch cycle");
        chk(pc_write === tk && fetch_hold === tk, "pc write or dead cycle wrong");
    endtask

    task t_not_neg;
        br(8'he7, 8'h05, 3'b011, 1'b1, 1'b1, 1'b1);
        br(8'he7, 8'h05, 3'b100, 1'b1, 1'b0, 1'b1);
    endtask

    task t_not_ovf;
        br(8'he5, 8'hf0, 3'b101, 1'b1, 1'b1, 1'b1);
        br(8'he5, 8'hf0, 3'b010, 1'b1, 1'b0, 1'b1);
    endtask

    task t_not_zero;
        br(8'he1, 8'h21, 3'b110, 1'b1, 1'b1, 1'b1);
        br(8'he1, 8'h21, 3'b001, 1'b1, 1'b0, 1'b1);
    endtask

    // extreme offsets back to back
    task t_offsets;
        br(8'he1, 8'h80, 3'b000, 1'b1, 1'b1, 1'b1);
        br(8'he1, 8'h7f, 3'b000, 1'b1, 1'b1, 1'b1);
    endtask

    task t_not_branch;
        br(8'he2, 8'h10, 3'b000, 1'b1, 1'b0, 1'b0);
        br(8'he7, 8'h10, 3'b000, 1'b0, 1'b0, 1'b0);
    endtask

    task t_reset;
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(negedge core_clk);
        chk(pc === 21'h000000 && q_phase === 2'h0 && pc_write === 1'b0, "reset state wrong");
        @(posedge core_clk);
        arst_n <= 1'b1;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            final_report;
        end
    end

    initial begin
        arst_n   = 1'b0;
        word_in  = 16'h0000;
        valid_in = 1'b1;
        flags_in = cbd_flags_s'(3'b000);
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        t_not_neg;
        t_not_ovf;
        t_not_zero;
        t_offsets;
        t_not_branch;
        t_reset;
        t_not_zero;
        final_report;
    end
endmodule
